// >>> rtl/rbs_pkg.sv
package rbs_pkg;

    // bus geometry: one 8-bit register per aligned 32-bit word
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_POWER_CTRL = 8'h87;
    localparam logic [IDX_W-1:0] IDX_RESET_CAUSE = 8'h96;
    localparam logic [IDX_W-1:0] IDX_CHIP_CTRL = 8'h9f;
    localparam logic [IDX_W-1:0] IDX_WDOG_CTRL = 8'haa;
    localparam logic [IDX_W-1:0] IDX_ACCESS_KEY = 8'hc7;
    localparam logic [IDX_W-1:0] IDX_BOOT_CFG = 8'hd0;
    localparam logic [IDX_W-1:0] IDX_PORT_BASE = 8'hd8;
    localparam logic [IDX_W-1:0] IDX_INT_TIMER_EN = 8'hdc;
    localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 8'he0;
    localparam logic [IDX_W-1:0] IDX_EVT_MASK = 8'he1;
    localparam int NUM_PORTS = 4;

    // chip_control fields
    localparam int CC_SOFT_RESET = 7;
    localparam int CC_ISP_FLAG = 6;
    localparam int CC_LOADER_UPD = 5;
    localparam int CC_XRAM_EN = 4;
    localparam int CC_BOOT_CHOICE = 1;
    localparam int CC_ISP_EN = 0;

    // watchdog_control fields
    localparam int WC_ENABLE = 7;
    localparam int WC_CLEAR = 6;
    localparam int WC_PD_RUN = 4;
    localparam int WC_CAUSE = 3;
    localparam int WC_PRESCALE_LO = 0;
    localparam int WC_PRESCALE_W = 3;

    // reset_cause_register, power control and config fields
    localparam int RC_SOFT_CAUSE = 0;
    localparam int PC_POWER_ON = 4;
    localparam int PC_GEN_HI = 3;
    localparam int PC_GEN_LO = 2;
    localparam int CFG_BOOT_CHOICE = 7;

    // event status bits
    localparam int EV_RESET_DONE = 0;
    localparam int EV_ACCESS_VIOL = 1;
    localparam int EV_WDOG_EXPIRED = 2;
    localparam int EV_W = 3;

    // reset values
    localparam logic [7:0] CFG_RESET = 8'hff;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] INT_TIMER_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SP_RESET = 8'h07;

    // timed-access key bytes
    localparam logic [7:0] KEY_FIRST = 8'haa;
    localparam logic [7:0] KEY_SECOND = 8'h55;

    // timing: clocks per machine cycle, internal reset length
    localparam int MC_CLKS = 12;
    localparam int RST_HOLD_MC = 2;
    localparam int RST_HOLD_CLKS = RST_HOLD_MC * MC_CLKS;
    localparam int WDT_BASE = 6;
    localparam int WDT_CNT_W = 24;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {SEQ_RUN, SEQ_HOLD} rbs_seq_e;
    typedef enum logic [1:0] {TA_LOCKED, TA_GOT_FIRST, TA_OPEN} rbs_ta_e;

endpackage : rbs_pkg

// >>> rtl/rbs_top.sv
`timescale 1ns/1ps

// How it works
// - free-running watchdog, software clear restarts count
// - watchdog expiry resets system two machine cycles
// - watchdog cause flag kept except power-on
// - unlocked write of command bit starts reset
// - command bit self-clears after reset; reads zero
// - software reset sets its cause flag
// - boot bit write picks next boot block
// - boot bit read shows last boot block
// - non-software resets reload boot bit inverted
// - config choice: one application, zero loader
// - boot decided from boot bit at release
// - reset never touches on-chip RAM
// - program counter held 0000 during reset
// - reset loads stack pointer with 07
// - reset disables interrupts and timers
// - reset writes FF into port registers
// - other registers return to initial values, except boot config, cause flags, event status and event mask
// - power-on flag set by power-on, or by a software write of one to its bit
module rbs_top
    import rbs_pkg::*;
#(
    parameter int MC_CYCLES = MC_CLKS,
    parameter int WDT_SHIFT = WDT_BASE
) (
    // clock and power-on reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // other reset sources, pin or brown-out, held high to reset
    input wire logic EXT_RESET,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [DATA_W/8-1:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // core-facing reset state
    output logic CPU_RESET,
    output logic BOOT_FROM_LOADER,
    output logic [15:0] PC_INIT,
    output logic [7:0] SP_INIT,
    output logic [8*NUM_PORTS-1:0] PORT_OUT,
    output logic [7:0] INT_TIMER_EN,
    output logic RAM_CLEAR,
    // interrupt
    output logic IRQ
);

    // map decode shared by read and write paths
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[IDX_W+1:2];
        reg_hit = (addr[ADDR_W-1:IDX_W+2] == '0) &&
            (idx == IDX_POWER_CTRL || idx == IDX_RESET_CAUSE ||
             idx == IDX_CHIP_CTRL || idx == IDX_WDOG_CTRL ||
             idx == IDX_ACCESS_KEY || idx == IDX_BOOT_CFG ||
             (idx >= IDX_PORT_BASE && idx < IDX_PORT_BASE + IDX_W'(NUM_PORTS)) ||
             idx == IDX_INT_TIMER_EN || idx == IDX_EVT_STATUS || idx == IDX_EVT_MASK);
    endfunction : reg_hit

    // watchdog terminal count per prescale setting
    function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [WC_PRESCALE_W-1:0] ps);
        wdt_limit = WDT_CNT_W'((64'h1 << (WDT_SHIFT + int'(ps))) - 64'h1);
    endfunction : wdt_limit

    // bus state
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_have_r, w_have_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [DATA_W-1:0] rdata_r;

    // block state
    rbs_seq_e seq_r;
    rbs_ta_e ta_r;
    logic [7:0] hold_cnt_r;
    logic non_soft_r;
    logic soft_cmd_r;
    logic soft_cause_r;
    logic [7:0] mc_cnt_r;
    logic [WDT_CNT_W-1:0] wdt_cnt_r;
    logic wdt_en_r, wdt_pd_r;
    logic [WC_PRESCALE_W-1:0] wdt_ps_r;
    logic wdt_flag_r, soft_flag_r, por_flag_r;
    logic [1:0] gen_flags_r;
    logic isp_flag_r, ldr_upd_r, xram_en_r, isp_en_r;
    logic next_boot_r, booted_r;
    logic [7:0] cfg_r;
    logic [7:0] port_r [NUM_PORTS];
    logic [7:0] int_timer_r;
    logic [EV_W-1:0] evt_r, mask_r;
    logic sys_rst_r, boot_out_r, irq_r;
    logic [15:0] pc_r;
    logic [7:0] sp_r;
    logic ram_clr_r;

    // write decode, one accepted write per wr_fire
    wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
    wire wr_hit = reg_hit(awaddr_r);
    wire [IDX_W-1:0] wr_idx = awaddr_r[IDX_W+1:2];
    wire wr_en = wr_fire && wr_hit && wstrb0_r && (seq_r == SEQ_RUN);
    wire unlocked = (ta_r == TA_OPEN);
    wire wr_key = wr_en && wr_idx == IDX_ACCESS_KEY;
    wire wr_prot = wr_en && (wr_idx == IDX_CHIP_CTRL || wr_idx == IDX_WDOG_CTRL);
    wire wr_chip = wr_prot && unlocked && wr_idx == IDX_CHIP_CTRL;
    wire wr_wdog = wr_prot && unlocked && wr_idx == IDX_WDOG_CTRL;
    wire viol = wr_prot && !unlocked;
    wire wr_cause = wr_en && wr_idx == IDX_RESET_CAUSE;
    wire wr_power = wr_en && wr_idx == IDX_POWER_CTRL;
    wire wr_cfg = wr_en && wr_idx == IDX_BOOT_CFG;
    wire wr_ite = wr_en && wr_idx == IDX_INT_TIMER_EN;
    wire wr_evt = wr_en && wr_idx == IDX_EVT_STATUS;
    wire wr_mask = wr_en && wr_idx == IDX_EVT_MASK;
    wire [IDX_W-1:0] port_sel = wr_idx - IDX_PORT_BASE;

    // timed-access key: 0xaa then 0x55, the very next mapped write consumes it
    wire rbs_ta_e ta_nxt = !wr_en ? ta_r :
        (wr_key && wdata_r == KEY_FIRST) ? TA_GOT_FIRST :
        (wr_key && ta_r == TA_GOT_FIRST && wdata_r == KEY_SECOND) ? TA_OPEN :
        TA_LOCKED;

    // machine-cycle tick and watchdog
    wire mc_tick = (mc_cnt_r == 8'(MC_CYCLES - 1));
    wire wdt_clear = wr_wdog && wdata_r[WC_CLEAR];
    wire wdt_expire = (seq_r == SEQ_RUN) && wdt_en_r && mc_tick &&
        (wdt_cnt_r == wdt_limit(wdt_ps_r)) && !wdt_clear;

    // reset sequencer: each source holds the system for two machine cycles, counted from release for a pin reset
    wire enter = (seq_r == SEQ_RUN) && (wdt_expire || soft_cmd_r || EXT_RESET);
    wire hold_done = (seq_r == SEQ_HOLD) && !EXT_RESET &&
        (hold_cnt_r == 8'(RST_HOLD_MC * MC_CYCLES - 1));
    wire rbs_seq_e seq_nxt = enter ? SEQ_HOLD : (hold_done ? SEQ_RUN : seq_r);
    wire holding = (seq_r == SEQ_HOLD);

    // event flags: set wins over write-one-to-clear
    wire [EV_W-1:0] evt_set = {wdt_expire, viol, hold_done};
    wire [EV_W-1:0] evt_clr = wr_evt ? wdata_r[EV_W-1:0] : '0;
    wire [EV_W-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

    // read mux, reserved bits and the key register read as zero
    wire [IDX_W-1:0] rd_idx = ARADDR[IDX_W+1:2];
    wire rd_hit = reg_hit(ARADDR);
    wire [IDX_W-1:0] rd_port = rd_idx - IDX_PORT_BASE;
    wire [7:0] chip_rd = {1'b0, isp_flag_r, ldr_upd_r, xram_en_r, 2'b00, booted_r,
        isp_en_r};
    wire [7:0] wdog_rd = {wdt_en_r, 1'b0, 1'b0, wdt_pd_r, wdt_flag_r, wdt_ps_r};
    wire [7:0] power_rd = {3'b000, por_flag_r, gen_flags_r, 2'b00};
    wire [7:0] rd_byte =
        (rd_idx == IDX_CHIP_CTRL) ? chip_rd :
        (rd_idx == IDX_WDOG_CTRL) ? wdog_rd :
        (rd_idx == IDX_POWER_CTRL) ? power_rd :
        (rd_idx == IDX_RESET_CAUSE) ? {7'h00, soft_flag_r} :
        (rd_idx == IDX_BOOT_CFG) ? cfg_r :
        (rd_idx == IDX_INT_TIMER_EN) ? int_timer_r :
        (rd_idx == IDX_EVT_STATUS) ? {5'h00, evt_r} :
        (rd_idx == IDX_EVT_MASK) ? {5'h00, mask_r} :
        (rd_idx >= IDX_PORT_BASE && rd_idx < IDX_PORT_BASE + IDX_W'(NUM_PORTS)) ?
            port_r[rd_port[1:0]] : 8'h00;

    // write channels: address and data taken in either order
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            if (AWVALID && awready_r) begin
                awaddr_r <= AWADDR;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end else if (wr_fire) begin
                aw_have_r <= 1'b0;
                awready_r <= 1'b1;
            end
            if (WVALID && wready_r) begin
                wdata_r <= WDATA[7:0];
                wstrb0_r <= WSTRB[0];
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end else if (wr_fire) begin
                w_have_r <= 1'b0;
                wready_r <= 1'b1;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY && bvalid_r) begin
            bvalid_r <= 1'b0;
        end
    end

    // read channel, one answer per address, data captured at the handshake
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ARVALID && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_hit ? rd_byte : 8'h00};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY && rvalid_r) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // sequencer; power-on enters the hold directly as a non-software reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seq_r <= SEQ_HOLD;
            hold_cnt_r <= 8'h00;
            non_soft_r <= 1'b1;
            soft_cause_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            hold_cnt_r <= (holding && !EXT_RESET && !hold_done) ? hold_cnt_r + 8'h01 : 8'h00;
            if (enter) begin
                non_soft_r <= wdt_expire || EXT_RESET;
                soft_cause_r <= soft_cmd_r;
            end else if (holding && EXT_RESET) begin
                non_soft_r <= 1'b1; // a pin reset overlapping counts too
            end
        end
    end

    // software reset command bit, cleared once the reset has finished
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            soft_cmd_r <= 1'b0;
        end else if (hold_done) begin
            soft_cmd_r <= 1'b0;
        end else if (wr_chip && wdata_r[CC_SOFT_RESET]) begin
            soft_cmd_r <= 1'b1;
        end
    end

    // timed-access state, relocked by any system reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ta_r <= TA_LOCKED;
        end else begin
            ta_r <= holding ? TA_LOCKED : ta_nxt;
        end
    end

    // machine-cycle prescaler and watchdog counter, restarted by clear
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mc_cnt_r <= 8'h00;
            wdt_cnt_r <= '0;
        end else begin
            mc_cnt_r <= mc_tick ? 8'h00 : mc_cnt_r + 8'h01;
            if (holding || wdt_clear || !wdt_en_r || wdt_expire) begin
                wdt_cnt_r <= '0;
            end else if (mc_tick) begin
                wdt_cnt_r <= wdt_cnt_r + 1'b1;
            end
        end
    end

    // watchdog control; the system reset restores it to disabled
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdt_en_r <= 1'b0;
            wdt_pd_r <= 1'b0;
            wdt_ps_r <= '0;
        end else if (holding) begin
            wdt_en_r <= 1'b0;
            wdt_pd_r <= 1'b0;
            wdt_ps_r <= '0;
        end else if (wr_wdog) begin
            wdt_en_r <= wdata_r[WC_ENABLE];
            wdt_pd_r <= wdata_r[WC_PD_RUN];
            wdt_ps_r <= wdata_r[WC_PRESCALE_LO +: WC_PRESCALE_W];
        end
    end

    // cause flags survive every reset but power-on; hardware set wins
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdt_flag_r <= 1'b0;
            soft_flag_r <= 1'b0;
            por_flag_r <= 1'b1;
        end else begin
            if (wdt_expire) begin
                wdt_flag_r <= 1'b1;
            end else if (wr_wdog) begin
                wdt_flag_r <= wdata_r[WC_CAUSE];
            end
            if (hold_done && soft_cause_r) begin
                soft_flag_r <= 1'b1;
            end else if (wr_cause) begin
                soft_flag_r <= wdata_r[RC_SOFT_CAUSE];
            end
            if (wr_power) begin
                por_flag_r <= wdata_r[PC_POWER_ON];
            end
        end
    end

    // chip control and general flags go back to initial values on reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            isp_flag_r <= 1'b0;
            ldr_upd_r <= 1'b0;
            xram_en_r <= 1'b0;
            isp_en_r <= 1'b0;
            gen_flags_r <= 2'b00;
        end else if (holding) begin
            isp_flag_r <= 1'b0;
            ldr_upd_r <= 1'b0;
            xram_en_r <= 1'b0;
            isp_en_r <= 1'b0;
            gen_flags_r <= 2'b00;
        end else begin
            if (wr_chip) begin
                isp_flag_r <= wdata_r[CC_ISP_FLAG];
                ldr_upd_r <= wdata_r[CC_LOADER_UPD];
                xram_en_r <= wdata_r[CC_XRAM_EN];
                isp_en_r <= wdata_r[CC_ISP_EN];
            end
            if (wr_power) begin
                gen_flags_r <= wdata_r[PC_GEN_HI:PC_GEN_LO];
            end
        end
    end

    // boot choice: written value picks the next boot, read shows the last
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            next_boot_r <= 1'b0;
            booted_r <= 1'b0;
            cfg_r <= CFG_RESET;
        end else begin
            if (holding && non_soft_r) begin
                next_boot_r <= ~cfg_r[CFG_BOOT_CHOICE];
            end else if (wr_chip) begin
                next_boot_r <= wdata_r[CC_BOOT_CHOICE];
            end
            if (hold_done) begin
                booted_r <= next_boot_r;
            end
            if (wr_cfg) begin
                cfg_r <= wdata_r;
            end
        end
    end

    // ports, interrupt and timer enables; pc and sp presets
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                port_r[i] <= PORT_RESET;
            end
            int_timer_r <= INT_TIMER_RESET;
            pc_r <= PC_RESET;
            sp_r <= SP_RESET;
        end else if (holding) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                port_r[i] <= PORT_RESET;
            end
            int_timer_r <= INT_TIMER_RESET;
            pc_r <= PC_RESET;
            sp_r <= SP_RESET;
        end else begin
            if (wr_en && wr_idx >= IDX_PORT_BASE &&
                    wr_idx < IDX_PORT_BASE + IDX_W'(NUM_PORTS)) begin
                port_r[port_sel[1:0]] <= wdata_r;
            end
            if (wr_ite) begin
                int_timer_r <= wdata_r;
            end
        end
    end

    // events and interrupt; kept across system resets so software sees them
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            evt_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            evt_r <= evt_nxt;
            if (wr_mask) begin
                mask_r <= wdata_r[EV_W-1:0];
            end
            irq_r <= |(evt_nxt & (wr_mask ? wdata_r[EV_W-1:0] : mask_r));
        end
    end

    // core-facing outputs; boot block latched only at release
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sys_rst_r <= 1'b1;
            boot_out_r <= 1'b0;
            ram_clr_r <= 1'b0;
        end else begin
            sys_rst_r <= (seq_nxt == SEQ_HOLD);
            if (hold_done) begin
                boot_out_r <= next_boot_r;
            end
            ram_clr_r <= 1'b0;
        end
    end

    // registered outputs
    assign AWREADY = awready_r;
    assign WREADY = wready_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = arready_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign CPU_RESET = sys_rst_r;
    assign BOOT_FROM_LOADER = boot_out_r;
    assign PC_INIT = pc_r;
    assign SP_INIT = sp_r;
    assign PORT_OUT = {port_r[3], port_r[2], port_r[1], port_r[0]};
    assign INT_TIMER_EN = int_timer_r;
    assign RAM_CLEAR = ram_clr_r;
    assign IRQ = irq_r;

endmodule : rbs_top

// >>> verif/rbs_top_assertions.sv
`timescale 1ns/1ps
module rbs_checker
    import rbs_pkg::*;
#(
    parameter int MC_CYCLES = MC_CLKS
) (
    // clock and resets
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic EXT_RESET,
    // read channel
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic RVALID,
    // core-facing reset state
    input wire logic CPU_RESET,
    input wire logic BOOT_FROM_LOADER,
    input wire logic [15:0] PC_INIT,
    input wire logic [7:0] SP_INIT,
    input wire logic [8*NUM_PORTS-1:0] PORT_OUT,
    input wire logic [7:0] INT_TIMER_EN,
    input wire logic RAM_CLEAR
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic [7:0] hold_cnt_r;
    logic ext_r;
    logic rd_chip_r;
    // hold length; a pin reset stretches the hold, so such holds are left out
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_cnt_r <= 8'h00;
            ext_r <= 1'b0;
            rd_chip_r <= 1'b0;
        end else begin
            hold_cnt_r <= CPU_RESET ? hold_cnt_r + 8'h01 : 8'h00;
            ext_r <= CPU_RESET & (ext_r | EXT_RESET);
            if (ARVALID && ARREADY) rd_chip_r <= (ARADDR[9:2] == IDX_CHIP_CTRL);
        end
    end
    sequence s_hold_end;
        $fell(CPU_RESET) && !ext_r;
    endsequence
    a_hold_two_mc: assert property (s_hold_end |->
        hold_cnt_r inside {[2*MC_CYCLES-1:2*MC_CYCLES+1]}) else $error("reset hold length off");
    a_pc_held: assert property (CPU_RESET && $past(CPU_RESET) |-> PC_INIT == 16'h0000)
        else $error("program counter not held at zero");
    a_sp_loaded: assert property ($fell(CPU_RESET) |-> SP_INIT == 8'h07)
        else $error("stack pointer not 07");
    a_ports_high: assert property ($fell(CPU_RESET) |-> PORT_OUT == {NUM_PORTS{8'hff}})
        else $error("ports not all high after reset");
    a_int_off: assert property ($fell(CPU_RESET) |-> INT_TIMER_EN == 8'h00)
        else $error("interrupts or timers enabled after reset");
    a_ram_kept: assert property (RAM_CLEAR == 1'b0)
        else $error("ram clear raised");
    a_boot_at_release: assert property ($changed(BOOT_FROM_LOADER) |->
        $past(CPU_RESET) || $past(CPU_RESET, 2)) else $error("boot block changed outside reset");
    a_cmd_reads_zero: assert property (RVALID && rd_chip_r |-> RDATA[CC_SOFT_RESET] == 1'b0)
        else $error("reset command bit read as one");
endmodule : rbs_checker

bind rbs_top rbs_checker #(.MC_CYCLES(MC_CYCLES)) u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .EXT_RESET(EXT_RESET), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RVALID(RVALID), .CPU_RESET(CPU_RESET), .BOOT_FROM_LOADER(BOOT_FROM_LOADER),
    .PC_INIT(PC_INIT), .SP_INIT(SP_INIT), .PORT_OUT(PORT_OUT), .INT_TIMER_EN(INT_TIMER_EN),
    .RAM_CLEAR(RAM_CLEAR));

// >>> verif/rbs_top_bench.sv
`timescale 1ns/1ps
module rbs_top_bench
    import rbs_pkg::*;
;
    logic SYS_CLK = 1'b0, ARST_N = 1'b0, EXT_RESET = 1'b0;
    logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
    logic [DATA_W-1:0] WDATA = '0, RDATA;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CPU_RESET, BOOT_FROM_LOADER, RAM_CLEAR, IRQ;
    logic [1:0] BRESP, RRESP, resp;
    logic [15:0] PC_INIT;
    logic [7:0] SP_INIT, INT_TIMER_EN, rdv, cfg;
    logic [8*NUM_PORTS-1:0] PORT_OUT;
    logic [7:0] exp_port [NUM_PORTS];
    int fails = 0;
    int cmp_count = 0;

    // short machine cycle and watchdog span keep the run brief
    rbs_top #(.MC_CYCLES(2), .WDT_SHIFT(1)) DUT (.SYS_CLK, .ARST_N, .EXT_RESET, .AWADDR,
        .AWPROT(3'h0), .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf), .WVALID, .WREADY, .BRESP,
        .BVALID, .BREADY, .ARADDR, .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
        .RREADY, .CPU_RESET, .BOOT_FROM_LOADER, .PC_INIT, .SP_INIT, .PORT_OUT, .INT_TIMER_EN,
        .RAM_CLEAR, .IRQ);

    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    function automatic logic boot_exp(input logic [7:0] c);
        return ~c[7];
    endfunction : boot_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // valids drop once taken; ready for the answer stays up until it comes
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AWADDR <= {2'b00, idx, 2'b00};
        WDATA <= {24'h000000, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID && n < 100);
        if (n >= 100) fails++;
        resp = BRESP;
        BREADY <= 1'b0;
    endtask : wr

    task automatic rdreg(input logic [7:0] idx);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        ARADDR <= {2'b00, idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID && n < 100);
        if (n >= 100) fails++;
        rdv = RDATA[7:0];
        resp = RRESP;
        RREADY <= 1'b0;
    endtask : rdreg

    task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        rdreg(idx);
        chk(rdv & m, e);
    endtask : rdc

    task automatic unlock;
        wr(IDX_ACCESS_KEY, 8'haa);
        wr(IDX_ACCESS_KEY, 8'h55);
    endtask : unlock

    // bounded wait for a system reset to start and end
    task automatic wait_rel;
        int n;
        n = 0;
        while (!CPU_RESET && n < 80) begin
            @(posedge SYS_CLK);
            n++;
        end
        chk(CPU_RESET, 1'b1);
        while (CPU_RESET && n < 400) begin
            @(posedge SYS_CLK);
            n++;
        end
        chk(CPU_RESET, 1'b0);
        repeat (2) @(posedge SYS_CLK);
    endtask : wait_rel

    task automatic pin_reset;
        @(posedge SYS_CLK);
        EXT_RESET <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        EXT_RESET <= 1'b0;
        wait_rel();
    endtask : pin_reset

    task automatic stop_test;
        $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        #300us;
        fails++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h01315fea));
        repeat (16) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        wait_rel();
        chk(BOOT_FROM_LOADER, boot_exp(8'hff));
        rdc(IDX_POWER_CTRL, 8'h10, 8'h10);
        rdc(IDX_CHIP_CTRL, 8'h82, 8'h00);
        rdc(IDX_INT_TIMER_EN, 8'hff, 8'h00);
        rdc(IDX_PORT_BASE, 8'hff, 8'hff);
        rdreg(8'h01);
        chk(resp, RESP_SLVERR);
        // protected write without the key is dropped and flagged
        wr(IDX_EVT_MASK, 8'h02);
        wr(IDX_CHIP_CTRL, 8'h10);
        chk(resp, RESP_OKAY);
        rdc(IDX_CHIP_CTRL, 8'h10, 8'h00);
        chk(IRQ, 1'b1);
        wr(IDX_EVT_STATUS, 8'h02);
        repeat (3) @(posedge SYS_CLK);
        chk(IRQ, 1'b0);
        // an unrelated write between key and target relocks
        unlock();
        wr(IDX_PORT_BASE, 8'h5a);
        wr(IDX_CHIP_CTRL, 8'h10);
        rdc(IDX_CHIP_CTRL, 8'h10, 8'h00);
        unlock();
        wr(IDX_CHIP_CTRL, 8'h12);
        rdc(IDX_CHIP_CTRL, 8'h12, 8'h10);
        wr(IDX_POWER_CTRL, 8'h00);
        wr(IDX_RESET_CAUSE, 8'h00);
        unlock();
        wr(IDX_CHIP_CTRL, 8'h82);
        wait_rel();
        chk(BOOT_FROM_LOADER, 1'b1);
        rdc(IDX_CHIP_CTRL, 8'h82, 8'h02);
        rdc(IDX_RESET_CAUSE, 8'h01, 8'h01);
        rdc(IDX_POWER_CTRL, 8'h10, 8'h00);
        // random port and enable contents, wiped by the next pin reset
        for (int i = 0; i < NUM_PORTS; i++) begin
            exp_port[i] = 8'($urandom);
            wr(IDX_PORT_BASE + 8'(i), exp_port[i]);
            rdc(IDX_PORT_BASE + 8'(i), 8'hff, exp_port[i]);
            chk(PORT_OUT[8*i +: 8], exp_port[i]);
        end
        wr(IDX_INT_TIMER_EN, 8'($urandom));
        cfg = {1'b0, 7'($urandom)};
        wr(IDX_BOOT_CFG, cfg);
        pin_reset();
        chk(BOOT_FROM_LOADER, boot_exp(cfg));
        chk(PORT_OUT, {NUM_PORTS{8'hff}});
        chk(INT_TIMER_EN, 8'h00);
        rdc(IDX_RESET_CAUSE, 8'h01, 8'h01);
        wr(IDX_BOOT_CFG, 8'hff);
        unlock();
        wr(IDX_CHIP_CTRL, 8'h82);
        wait_rel();
        chk(BOOT_FROM_LOADER, 1'b1);
        pin_reset();
        chk(BOOT_FROM_LOADER, boot_exp(8'hff));
        // watchdog last: its expiry resets the system, and that reset disables the watchdog again
        unlock();
        wr(IDX_WDOG_CTRL, 8'h80);
        wait_rel();
        rdc(IDX_WDOG_CTRL, 8'h08, 8'h08);
        stop_test();
    end
endmodule : rbs_top_bench
